// File: tpc_pkg.sv
// constants and types shared by the timer16 capture/compare/pwm block
// What this block does
// - pwm active width from compare A upper 14
// - output control bit 1 picks active level
// - pwm 14-bit: 2^8 base, 2^14 subcycle
// - clock select bits 4..6 pick count clock
// - output control bit 0 enables output
// - pulse mode: period compare A, active from B to A
// - free-run: trigger A edge captures B, irq A
// - edge select A bits 2..3: rise/fall/both
// - trigger A sampled, two equal samples needed
// - dual mode: trigger B captures A, irq B
// - opposite trigger A edge captures into A
// - both-edges select blocks captures into A
// - restart mode: capture B then clear counter
// - zero mode field stops the counter
package tpc_pkg;
  // register byte offsets
  localparam logic [3:0] TPC_OFS_MODE   = 4'h0;
  localparam logic [3:0] TPC_OFS_CCTRL  = 4'h1;
  localparam logic [3:0] TPC_OFS_OUTCTL = 4'h2;
  localparam logic [3:0] TPC_OFS_EDGE   = 4'h3;
  localparam logic [3:0] TPC_OFS_SAMPLE = 4'h4;
  localparam logic [3:0] TPC_OFS_CLKSEL = 4'h5;
  localparam logic [3:0] TPC_OFS_CMPA   = 4'h6;
  localparam logic [3:0] TPC_OFS_CMPB   = 4'h7;
  localparam logic [3:0] TPC_OFS_COUNT  = 4'h8;
  localparam logic [3:0] TPC_OFS_STATUS = 4'h9;
  localparam logic [3:0] TPC_OFS_MASK   = 4'hA;
  // field positions
  localparam int TPC_MODE_LSB  = 1;
  localparam int TPC_OE_BIT    = 0;
  localparam int TPC_LVL_BIT   = 1;
  localparam int TPC_ESA_LSB   = 2;
  localparam int TPC_ESB_LSB   = 4;
  localparam int TPC_CLK_LSB   = 4;
  // timer mode field codes
  localparam logic [2:0] TPC_MD_STOP    = 3'h0;
  localparam logic [2:0] TPC_MD_PWM     = 3'h1;
  localparam logic [2:0] TPC_MD_PULSE   = 3'h2;
  localparam logic [2:0] TPC_MD_FREE    = 3'h3;
  localparam logic [2:0] TPC_MD_DUAL    = 3'h4;
  localparam logic [2:0] TPC_MD_TWOCAP  = 3'h5;
  localparam logic [2:0] TPC_MD_RESTART = 3'h6;
  // edge select codes
  localparam logic [1:0] TPC_ES_FALL = 2'h0;
  localparam logic [1:0] TPC_ES_RISE = 2'h1;
  localparam logic [1:0] TPC_ES_BOTH = 2'h3;
  // count clock code for the external trigger-a edge
  localparam logic [2:0] TPC_CK_EXT = 3'h0;
  // reset values
  localparam logic [7:0]  TPC_RST_BYTE = 8'h00;
  localparam logic [15:0] TPC_RST_WORD = 16'h0000;
  // pwm shape
  localparam int TPC_PWM_BITS = 14;
  localparam int TPC_BASE_BITS = 8;
  // status bits
  localparam int TPC_ST_IRQA = 0;
  localparam int TPC_ST_IRQB = 1;
endpackage : tpc_pkg

// File: tpc_edge_if.sv
// interface carrying a filtered trigger edge between submodules
`timescale 1ns/1ps
interface tpc_edge_if;
  logic rise;  // filtered rising edge pulse
  logic fall;  // filtered falling edge pulse
  logic level; // filtered level
  modport src (output rise, output fall, output level);
  modport dst (input rise, input fall, input level);
endinterface : tpc_edge_if

// File: tpc_edge_filter.sv
// sampled two-hit noise filter and edge detector for a trigger pin
`timescale 1ns/1ps
module tpc_edge_filter (
  input  wire logic    clk_sys,
  input  wire logic    rstSync_n,
  input  wire logic    pinIn,
  input  wire logic    sampleTick,
  input  wire logic    useFilter,
  tpc_edge_if.src      edge_o
);
  import tpc_pkg::*;
  logic syncA;   // first synchroniser stage
  logic syncB;   // second synchroniser stage
  logic lastSmp; // previous sample
  logic lvl;     // accepted level

  // two-flop synchroniser
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lastSmp <= 1'b0;
      lvl     <= 1'b0;
    end else if (!useFilter) begin
      lvl <= syncB;
    end else if (sampleTick) begin
      lastSmp <= syncB;
      if (lastSmp == syncB) begin
        lvl <= syncB;
      end
    end
  end

  // edge pulses from accepted level changes
  logic lvlQ; // delayed accepted level
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lvlQ <= 1'b0;
    end else begin
      lvlQ <= lvl;
    end
  end
  assign edge_o.rise  = lvl & ~lvlQ;
  assign edge_o.fall  = ~lvl & lvlQ;
  assign edge_o.level = lvl;
endmodule : tpc_edge_filter

// File: tpc_prescaler.sv
// free prescaler producing count and sampling ticks
`timescale 1ns/1ps
module tpc_prescaler #(
  parameter int DIV_BITS = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       rstSync_n,
  input  wire logic [2:0] clkSel,
  input  wire logic [1:0] smpSel,
  output logic            cntTick,
  output logic            smpTick
);
  import tpc_pkg::*;
  logic [DIV_BITS-1:0] div;      // free running divider
  logic [DIV_BITS-1:0] divNext;  // divider plus one
  logic [DIV_BITS-1:0] risers;   // bits that rise this cycle

  assign divNext = div + 1'b1;
  assign risers  = divNext & ~div;

  // divider runs every clock
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      div <= '0;
    end else begin
      div <= divNext;
    end
  end

  // count clock pick: code n gives clk_sys/2^(n-1)
  always_comb begin
    cntTick = 1'b0;
    if (clkSel != TPC_CK_EXT) begin
      cntTick = (clkSel == 3'h1) ? 1'b1 : risers[clkSel-3'h2];
    end
  end

  // sampling interval: 2^(smpSel+1) clocks
  assign smpTick = risers[{1'b0, smpSel}];
endmodule : tpc_prescaler

// File: tpc_timer16.sv
// top: 16-bit timer with pwm, pulse generation and capture, avalon slave
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tpc_timer16 (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        trigger_input_a,
  input  wire logic        trigger_input_b,
  output logic             timer_out_pin,
  output logic             timer_out_oe,
  output logic             ext_event_irq_a,
  output logic             ext_event_irq_b,
  output logic             irq
);
  import tpc_pkg::*;

  logic       rstMeta;   // reset synchroniser stage one
  logic       rstSync_n; // released reset
  // release reset through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstMeta   <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta   <= 1'b1;
      rstSync_n <= rstMeta;
    end
  end

  // software registers
  logic [7:0]  timer_mode_control;
  logic [7:0]  capture_compare_control;
  logic [7:0]  timer_output_control;
  logic [7:0]  edge_select_register;
  logic [7:0]  sampling_clock_select;
  logic [7:0]  clock_select_register;
  logic [15:0] compare_capture_a;
  logic [15:0] compare_capture_b;
  logic [15:0] timer_count;
  logic [1:0]  irqStatus;  // sticky event bits
  logic [1:0]  irqMask;    // interrupt enables
  logic        ackPhase;   // answer cycle of the slave

  logic [2:0]  mode;       // timer mode field
  logic [1:0]  esA;        // edge select a
  logic [1:0]  esB;        // edge select b
  assign mode = timer_mode_control[TPC_MODE_LSB +: 3];
  assign esA  = edge_select_register[TPC_ESA_LSB +: 2];
  assign esB  = edge_select_register[TPC_ESB_LSB +: 2];

  // bus strobes, one wait cycle per access
  logic wrHit;  // write accepted this cycle
  logic rdHit;  // read accepted this cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ackPhase;
  assign wrHit = avs_write & ackPhase;
  assign rdHit = avs_read & ackPhase;

  // answer phase toggles under a request
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ackPhase <= 1'b0;
    end else begin
      ackPhase <= (avs_read | avs_write) & ~ackPhase;
    end
  end

  // tick sources
  logic cntTickInt; // internal count tick
  logic smpTick;    // sampling tick
  tpc_prescaler #(.DIV_BITS(8)) u_pre (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .clkSel    (clock_select_register[TPC_CLK_LSB +: 3]),
    .smpSel    (sampling_clock_select[1:0]),
    .cntTick   (cntTickInt),
    .smpTick   (smpTick)
  );

  // trigger filters
  tpc_edge_if edgeA ();
  tpc_edge_if edgeB ();
  tpc_edge_filter u_fltA (
    .clk_sys    (clk_sys),
    .rstSync_n  (rstSync_n),
    .pinIn      (trigger_input_a),
    .sampleTick (smpTick),
    .useFilter  (1'b1),
    .edge_o     (edgeA)
  );
  tpc_edge_filter u_fltB (
    .clk_sys    (clk_sys),
    .rstSync_n  (rstSync_n),
    .pinIn      (trigger_input_b),
    .sampleTick (smpTick),
    .useFilter  (1'b0),
    .edge_o     (edgeB)
  );

  logic validA;   // selected trigger a edge
  logic oppA;     // opposite trigger a edge
  logic validB;   // selected trigger b edge
  always_comb begin
    case (esA)
      TPC_ES_FALL: validA = edgeA.fall;
      TPC_ES_RISE: validA = edgeA.rise;
      TPC_ES_BOTH: validA = edgeA.rise | edgeA.fall;
      default:     validA = 1'b0;
    endcase
    case (esA)
      TPC_ES_FALL: oppA = edgeA.rise;
      TPC_ES_RISE: oppA = edgeA.fall;
      default:     oppA = 1'b0;
    endcase
    case (esB)
      TPC_ES_FALL: validB = edgeB.fall;
      TPC_ES_RISE: validB = edgeB.rise;
      TPC_ES_BOTH: validB = edgeB.rise | edgeB.fall;
      default:     validB = 1'b0;
    endcase
  end

  // count tick: internal or trigger a edge
  logic cntTick;
  assign cntTick = (clock_select_register[TPC_CLK_LSB +: 3] == TPC_CK_EXT) ? validA : cntTickInt;

  logic isFree;     // counter in a measurement mode
  logic capBEv;     // capture into compare b
  logic capAEv;     // capture into compare a
  assign isFree = (mode == TPC_MD_FREE) | (mode == TPC_MD_DUAL) |
                  (mode == TPC_MD_TWOCAP) | (mode == TPC_MD_RESTART);
  // trigger a capture into compare b
  assign capBEv = isFree & validA;
  assign capAEv = ((mode == TPC_MD_DUAL) & validB) |
                  ((mode == TPC_MD_TWOCAP) & oppA);

  // counter
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      timer_count <= TPC_RST_WORD;
    end else if (mode == TPC_MD_STOP) begin
      timer_count <= TPC_RST_WORD;
    end else if ((mode == TPC_MD_RESTART) & validA) begin
      timer_count <= TPC_RST_WORD;
    end else if (cntTick) begin
      // pulse mode clears after period match
      if ((mode == TPC_MD_PULSE) && (timer_count == compare_capture_a)) begin
        timer_count <= TPC_RST_WORD;
      end else begin
        timer_count <= timer_count + 16'h0001;
      end
    end
  end

  // control register writes
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      timer_mode_control      <= TPC_RST_BYTE;
      capture_compare_control <= TPC_RST_BYTE;
      timer_output_control    <= TPC_RST_BYTE;
      edge_select_register    <= TPC_RST_BYTE;
      sampling_clock_select   <= TPC_RST_BYTE;
      clock_select_register   <= TPC_RST_BYTE;
      irqMask                 <= 2'h0;
    end else if (wrHit) begin
      case (avs_address)
        TPC_OFS_MODE:   timer_mode_control      <= avs_writedata[7:0];
        TPC_OFS_CCTRL:  capture_compare_control <= avs_writedata[7:0];
        TPC_OFS_OUTCTL: timer_output_control    <= avs_writedata[7:0];
        TPC_OFS_EDGE:   edge_select_register    <= avs_writedata[7:0];
        TPC_OFS_SAMPLE: sampling_clock_select   <= avs_writedata[7:0];
        TPC_OFS_CLKSEL: clock_select_register   <= avs_writedata[7:0];
        TPC_OFS_MASK:   irqMask                 <= avs_writedata[1:0];
        default:        ;
      endcase
    end
  end

  // compare registers: capture beats a software write
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      compare_capture_a <= TPC_RST_WORD;
      compare_capture_b <= TPC_RST_WORD;
    end else begin
      if (capAEv) begin
        compare_capture_a <= timer_count;
      end else if (wrHit && (avs_address == TPC_OFS_CMPA)) begin
        compare_capture_a <= avs_writedata[15:0];
      end
      if (capBEv) begin
        compare_capture_b <= timer_count;
      end else if (wrHit && (avs_address == TPC_OFS_CMPB)) begin
        compare_capture_b <= avs_writedata[15:0];
      end
    end
  end

  // sticky status; set wins over read clear
  logic [1:0] evts;
  assign evts = {isFree & validB & (mode == TPC_MD_DUAL), capBEv};
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irqStatus <= 2'h0;
    end else if (rdHit && (avs_address == TPC_OFS_STATUS)) begin
      irqStatus <= evts;
    end else begin
      irqStatus <= irqStatus | evts;
    end
  end
  assign irq = |(irqStatus & irqMask);

  // interrupt request pulses
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ext_event_irq_a <= 1'b0;
      ext_event_irq_b <= 1'b0;
    end else begin
      ext_event_irq_a <= evts[TPC_ST_IRQA];
      ext_event_irq_b <= evts[TPC_ST_IRQB];
    end
  end

  // read data register
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ackPhase) begin
      case (avs_address)
        TPC_OFS_MODE:   avs_readdata <= {24'h00_0000, timer_mode_control};
        TPC_OFS_CCTRL:  avs_readdata <= {24'h00_0000, capture_compare_control};
        TPC_OFS_OUTCTL: avs_readdata <= {24'h00_0000, timer_output_control};
        TPC_OFS_EDGE:   avs_readdata <= {24'h00_0000, edge_select_register};
        TPC_OFS_SAMPLE: avs_readdata <= {24'h00_0000, sampling_clock_select};
        TPC_OFS_CLKSEL: avs_readdata <= {24'h00_0000, clock_select_register};
        TPC_OFS_CMPA:   avs_readdata <= {16'h0000, compare_capture_a};
        TPC_OFS_CMPB:   avs_readdata <= {16'h0000, compare_capture_b};
        TPC_OFS_COUNT:  avs_readdata <= {16'h0000, timer_count};
        TPC_OFS_STATUS: avs_readdata <= {30'h0000_0000, irqStatus};
        TPC_OFS_MASK:   avs_readdata <= {30'h0000_0000, irqMask};
        default:        avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // pwm: base part from low count bits, extra pulse spread by sub-cycle
  logic [13:0] pwmDuty;  // active width code
  logic [7:0]  baseCnt;  // position within base cycle
  logic [5:0]  subIdx;   // base cycle index within sub-cycle
  logic [5:0]  subRev;   // bit reversed index
  logic        pwmAct;   // pwm active phase
  // width from upper 14 bits of compare a
  assign pwmDuty = compare_capture_a[15:2];
  assign baseCnt = timer_count[7:0];
  assign subIdx  = timer_count[13:8];
  for (genvar i = 0; i < 6; i++) begin : g_rev
    assign subRev[i] = subIdx[5-i];
  end
  assign pwmAct = ({1'b0, baseCnt} < {1'b0, pwmDuty[13:6]}) |
                  ((baseCnt == pwmDuty[13:6]) & (subRev < pwmDuty[5:0]));

  // pulse generator: active from compare b to compare a
  logic pulseAct; // pulse train active phase
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pulseAct <= 1'b0;
    end else if (mode != TPC_MD_PULSE) begin
      pulseAct <= 1'b0;
    end else if (cntTick && (timer_count == compare_capture_a)) begin
      pulseAct <= 1'b0;
    end else if (cntTick && (timer_count == compare_capture_b)) begin
      pulseAct <= 1'b1;
    end
  end

  // output pin with level select and enable
  logic lvlSel;
  assign lvlSel = timer_output_control[TPC_LVL_BIT];
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      timer_out_pin <= 1'b0;
      timer_out_oe  <= 1'b0;
    end else begin
      timer_out_oe <= timer_output_control[TPC_OE_BIT];
      if (mode == TPC_MD_PWM) begin
        timer_out_pin <= pwmAct ^ ~lvlSel;
      end else if (mode == TPC_MD_PULSE) begin
        timer_out_pin <= pulseAct ^ ~lvlSel;
      end else begin
        timer_out_pin <= ~lvlSel;
      end
    end
  end

  restart_clear_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    ((mode == TPC_MD_RESTART) && validA) |=> (timer_count == 16'h0000))
    else $error("restart did not clear counter");
  capture_b_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    capBEv |=> (compare_capture_b == $past(timer_count)))
    else $error("compare b capture wrong");
  stop_hold_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    (mode == TPC_MD_STOP) |=> (timer_count == 16'h0000))
    else $error("stopped counter moved");
  // both edges never capture into a in twocap
  both_nocap_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    ((mode == TPC_MD_TWOCAP) && (esA == TPC_ES_BOTH)) |-> !capAEv)
    else $error("capture into a with both edges");
  oe_follow_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    $changed(timer_output_control[TPC_OE_BIT]) |=> (timer_out_oe == $past(timer_output_control[TPC_OE_BIT])))
    else $error("output enable wrong");
  // dual capture into a and irq b
  dual_cap_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    ((mode == TPC_MD_DUAL) && validB) |=> (compare_capture_a == $past(timer_count)) && ext_event_irq_b)
    else $error("dual capture wrong");
  idle_level_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    (mode == TPC_MD_FREE) |=> (timer_out_pin == !$past(lvlSel)))
    else $error("idle level wrong");
  wrap_count_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    ((mode == TPC_MD_FREE) && cntTick && $stable(mode)) |=> (timer_count == $past(timer_count) + 16'h0001))
    else $error("free count step wrong");
  // pulse ends at the period match
  pulse_end_a: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
    ((mode == TPC_MD_PULSE) && cntTick && (timer_count == compare_capture_a)) |=> !pulseAct)
    else $error("pulse did not end at period");
endmodule : tpc_timer16

// File: tpc_pulse_src.sv
// behavioural model of the external pulse sources on the trigger pins
`timescale 1ns/1ps
module tpc_pulse_src (
  input  wire logic clk_sys,
  output logic      trigA,
  output logic      trigB
);
  // both sources idle low after power-up
  initial begin
    trigA = 1'b0;
    trigB = 1'b0;
  end
  // drive one pin level just after an edge, then hold it for some cycles
  task automatic drive(input bit sel, input logic v, input int hold);
    @(posedge clk_sys);
    // pick source b or source a
    if (sel) begin
      trigB <= v;
    end else begin
      trigA <= v;
    end
    repeat (hold) @(posedge clk_sys);
  endtask
endmodule // tpc_pulse_src

// File: tpc_timer16_tb_top.sv
// self-checking bench for the timer16 capture/compare/pwm block
`timescale 1ns/1ps
module tpc_timer16_tb_top;
  import tpc_pkg::*;
  logic        clk_sys;
  logic        nrst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        trigA;
  logic        trigB;
  logic        timerOut;
  logic        timerOe;
  logic        irqA;
  logic        irqB;
  logic        irq;
  int          fails;
  int          totalChecks;
  int          seed;
  int          hiCnt;
  bit          seen;
  logic [31:0] rd;
  logic [31:0] c1;
  logic [31:0] duty;
  logic [1:0]  es;

  tpc_timer16 DUT (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trigger_input_a(trigA), .trigger_input_b(trigB),
    .timer_out_pin(timerOut), .timer_out_oe(timerOe), .ext_event_irq_a(irqA),
    .ext_event_irq_b(irqB), .irq(irq));
  tpc_pulse_src pm (.clk_sys(clk_sys), .trigA(trigA), .trigB(trigB));

  // 250 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // exact value compare
  task automatic chkEq(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // value within a window compare
  task automatic chkIn(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
    totalChecks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      fails++;
      $display("[ERR] %s expected %0h..%0h seen %0h", nm, lo, hi, got);
    end
  endtask
  // active cycles of n pulse periods: period a+1 counts, width a-b counts
  function automatic logic [31:0] pulseHigh(input logic [31:0] a, input logic [31:0] b, input int n);
    return n * (a - b);
  endfunction
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // a slave that never answers ends the run
    if (n >= 50) begin
      fails++;
      wrap_up();
    end
  endtask
  // watch a fixed window for a capture event pulse
  task automatic waitEv(input bit b);
    seen = 0;
    repeat (200) begin
      @(posedge clk_sys);
      if ((b ? irqB : irqA) === 1'b1) seen = 1;
    end
  endtask
  // stop, program edges, sampling and clock, then start a mode
  task automatic setup(input logic [2:0] md, input logic [7:0] edg, input logic [1:0] smp);
    bus(1, TPC_OFS_MODE, 32'h0000_0000);
    bus(1, TPC_OFS_EDGE, {24'h0, edg});
    bus(1, TPC_OFS_SAMPLE, {30'h0, smp});
    bus(1, TPC_OFS_CLKSEL, 32'h0000_0010);
    bus(1, TPC_OFS_MODE, {28'h0, md, 1'b0});
  endtask
  // drive an edge, check the event and the captured count
  task automatic edgeCap(input bit b, input logic v, input bit expEv, input bit expCap, input logic [3:0] adr);
    bus(0, TPC_OFS_COUNT, 32'h0);
    c1 = rd;
    pm.drive(b, v, 0);
    waitEv(b);
    chkEq("capture event", {31'h0, expEv}, {31'h0, seen});
    // capture lands between the count before the edge and the window end
    if (expCap) begin
      bus(0, adr, 32'h0);
      chkIn("captured count", c1, c1 + 300, rd);
    end
  endtask

  initial begin
    seed = 18409;
    nrst = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    fails = 0;
    totalChecks = 0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // reset values, unmapped place, read-only counter while stopped
    bus(0, TPC_OFS_MODE, 32'h0);
    chkEq("mode reset", {24'h0, TPC_RST_BYTE}, rd);
    bus(0, 4'hF, 32'h0);
    chkEq("unmapped read", 32'h0, rd);
    bus(1, TPC_OFS_COUNT, 32'h0000_1234);
    bus(0, TPC_OFS_COUNT, 32'h0);
    chkEq("stopped count", 32'h0, rd);
    $display("test registers done");
    // pwm with random duty at both active levels over one sub-cycle
    for (int k = 0; k < 2; k++) begin
      duty = {18'h0, 14'($random(seed))};
      setup(TPC_MD_PWM, 8'h00, 2'h0);
      bus(1, TPC_OFS_CMPA, {duty[29:0], 2'b00});
      bus(1, TPC_OFS_OUTCTL, {30'h0, k[0], 1'b1});
      repeat (16700) @(posedge clk_sys);
      chkEq("output enable", 32'h1, {31'h0, timerOe});
      hiCnt = 0;
      repeat (16384) begin
        @(posedge clk_sys);
        hiCnt += (timerOut === 1'b1);
      end
      chkEq("pwm high count", k ? duty : 32'd16384 - duty, 32'(hiCnt));
    end
    bus(1, TPC_OFS_OUTCTL, 32'h0);
    repeat (2) @(posedge clk_sys);
    chkEq("output disabled", 32'h0, {31'h0, timerOe});
    $display("test pwm done");
    // free-run capture for every edge code, with interrupt status
    bus(1, TPC_OFS_MASK, 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      es = (k == 0) ? TPC_ES_FALL : (k == 1) ? TPC_ES_RISE : TPC_ES_BOTH;
      setup(TPC_MD_FREE, {4'h0, es, 2'b00}, 2'($random(seed)));
      edgeCap(0, 1, es != TPC_ES_FALL, es != TPC_ES_FALL, TPC_OFS_CMPB);
      chkEq("irq level", {31'h0, es != TPC_ES_FALL}, {31'h0, irq});
      bus(0, TPC_OFS_STATUS, 32'h0);
      chkEq("status a", {31'h0, es != TPC_ES_FALL}, {31'h0, rd[0]});
      @(negedge clk_sys);
      chkEq("irq cleared", 32'h0, {31'h0, irq});
      edgeCap(0, 0, es != TPC_ES_RISE, es != TPC_ES_RISE, TPC_OFS_CMPB);
    end
    $display("test free-run done");
    // short pulse below one sampling period is dropped
    setup(TPC_MD_FREE, 8'h0C, 2'h3);
    pm.drive(0, 1, 3);
    pm.drive(0, 0, 0);
    waitEv(0);
    chkEq("glitch rejected", 32'h0, {31'h0, seen});
    $display("test filter done");
    // two capture registers: opposite edge fills compare a
    setup(TPC_MD_TWOCAP, {4'h0, TPC_ES_RISE, 2'b00}, 2'h0);
    edgeCap(0, 1, 1, 1, TPC_OFS_CMPB);
    edgeCap(0, 0, 0, 1, TPC_OFS_CMPA);
    duty = rd;
    setup(TPC_MD_TWOCAP, 8'h0C, 2'h0);
    edgeCap(0, 1, 1, 0, TPC_OFS_CMPA);
    edgeCap(0, 0, 1, 0, TPC_OFS_CMPA);
    bus(0, TPC_OFS_CMPA, 32'h0);
    chkEq("compare a kept", duty, rd);
    $display("test two-capture done");
    // dual mode: trigger b fills compare a, masked then unmasked irq
    setup(TPC_MD_DUAL, {2'h0, TPC_ES_RISE, 4'h0}, 2'h0);
    bus(0, TPC_OFS_STATUS, 32'h0);
    edgeCap(1, 1, 1, 1, TPC_OFS_CMPA);
    chkEq("masked irq", 32'h0, {31'h0, irq});
    bus(1, TPC_OFS_MASK, 32'h0000_0002);
    @(negedge clk_sys);
    chkEq("unmasked irq", 32'h1, {31'h0, irq});
    bus(0, TPC_OFS_STATUS, 32'h0);
    chkEq("status b", 32'h2, {30'h0, rd[1:0]});
    @(negedge clk_sys);
    chkEq("irq b cleared", 32'h0, {31'h0, irq});
    pm.drive(1, 0, 0);
    $display("test dual done");
    // restart mode: capture then count again from zero
    setup(TPC_MD_RESTART, 8'h04, 2'h0);
    repeat (400) @(posedge clk_sys);
    edgeCap(0, 1, 1, 1, TPC_OFS_CMPB);
    bus(0, TPC_OFS_COUNT, 32'h0);
    chkIn("restarted count", 32'h0, 32'd255, rd);
    $display("test restart done");
    // pulse mode: random period and width, compares loaded while stopped
    bus(1, TPC_OFS_MODE, 32'h0);
    c1 = 32'h0000_0040 + {26'h0, 6'($random(seed))};
    duty = {26'h0, 6'($random(seed))};
    bus(1, TPC_OFS_CMPB, duty);
    bus(1, TPC_OFS_CMPA, c1);
    bus(1, TPC_OFS_OUTCTL, 32'h0000_0003);
    setup(TPC_MD_PULSE, 8'h00, 2'h0);
    repeat (300) @(posedge clk_sys);
    hiCnt = 0;
    repeat (4 * (c1 + 1)) begin
      @(posedge clk_sys);
      hiCnt += (timerOut === 1'b1);
    end
    chkEq("pulse high count", pulseHigh(c1, duty, 4), 32'(hiCnt));
    $display("test pulse done");
    wrap_up();
  end
endmodule // tpc_timer16_tb_top
